// [include/csr_params.svh]
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

// Control-space device codes (address bits 31..28)
`define CS_ROM        4'h0
`define CS_FAC        4'h4
`define CS_DMA        4'h5
`define CS_FLT        4'h6
`define CS_LED        4'h7

// Facility enable bit positions
`define FAC_DIAG      0
`define FAC_ACCEL     1
`define FAC_COPY      2
`define FAC_VIDEO     3
`define FAC_CACHE     4
`define FAC_SYSDMA    5
`define FAC_COPROC    6
`define FAC_BOOT_N    7

// Fault cause bit positions
`define FLT_ACCEL_DIS 2
`define FLT_ACCEL_ERR 3
`define FLT_SYSBUS    4
`define FLT_TIMEOUT   5
`define FLT_PROT      6
`define FLT_INVALID   7

// Reset values
`define FAC_RST       8'h00
`define DMA_RST       8'h00
`define FLT_RST       8'h00
`define LED_RST       8'h00

// Identity memory layout
`define ROM_BYTES     32
`define ROM_CKSUM     15
`define ROM_SUM_BYTES 16

// Virtual address window that times out when accelerator is supported
`define VA_TO_LO      4'h1
`define VA_TO_HI      4'hD

`endif

// [include/csr_pkg.sv]
package csr_pkg;

  // Control-space byte request from the processor
  typedef struct packed {
    logic       req;
    logic       we;
    logic [3:0] code;
    logic [4:0] addr;
    logic [7:0] wdata;
  } cs_req_s;

  // Control-space answer
  typedef struct packed {
    logic       ack;
    logic       berr;
    logic [7:0] rdata;
  } cs_rsp_s;

  // Device-space cycle seen after translation
  typedef struct packed {
    logic       valid;
    logic       dma;
    logic       user;
    logic       write;
    logic       sup_fetch;
    logic [3:0] va_top;
    logic       accel_sel;
    logic       accel_present;
    logic       accel_err;
    logic       sysbus;
    logic       sysbus_berr;
    logic       sysbus_timeout;
    logic       absent_target;
    logic       pte_valid;
    logic       pte_write;
    logic       pte_super;
  } dev_cyc_s;

  // Device-space answer
  typedef struct packed {
    logic ack;
    logic berr;
    logic to_eprom;
    logic to_accel;
  } dev_rsp_s;

  // Facility enables, bit 7 down to bit 0
  typedef struct packed {
    logic boot_n;
    logic coproc;
    logic sysdma;
    logic ext_cache;
    logic video;
    logic copy;
    logic accel;
    logic diag;
  } sys_en_s;

  // Control-space decode target
  typedef enum {T_ROM, T_FAC, T_DMA, T_FLT, T_LED, T_EXT, T_NONE} cs_tgt_e;

endpackage

// [hdl/control_space_regs.sv]
// Summary of operation
// - Identity bytes: format, type, six station, four date, three serial, checksum, reserved.
// - Checksum makes XOR of first sixteen identity bytes zero.
// - Date is a 32-bit seconds count from 1970.
// - Facility enables at code 4, byte R/W, cleared by power-on and watchdog.
// - Cleared facility register is all zero: boot active, facilities off.
// - Facility bits: diag, accel, copy, video, cache, bus DMA, coproc, boot bar.
// - Bit 0 reads the diagnostic switch, 1 means diagnostic position.
// - Accel access while disabled faults; enabled but absent accel times out.
// - Boot state steers supervisor fetches to the boot EPROM.
// - DMA permit register at code 4'h5, bit n permits context n.
// - Reset clears all DMA permits.
// - Synchronous processor cycle errors end in bus error and record cause.
// - Only those cycles and coprocessor timeouts update the cause latch.
// - Cause latch holds the most recent error, overwriting older ones.
// - Cause latch at code 6, read-only, bits 2..7 hold causes.
// - Accel error and system bus error responses set their bits.
// - Write to read-only page or user access to supervisor page faults.
// - Device cycle through invalid page entry sets invalid bit.
// - Unimplemented control-space code times out with bus error.
// - With accel support, virtual top nibble 1..D times out.
// - Absent memory, absent I/O, silent bus slave all time out.
// - LED latch write-only, zero lights, power-on clears it.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"

module control_space_regs #(
  parameter logic [7:0]  ROM_FORMAT    = 8'h01,
  parameter logic [7:0]  MACHINE_TYPE  = 8'h5A,       // Arbitrary value
  parameter logic [47:0] STATION_ADDR  = 48'h0200_0000_0001,
  parameter logic [31:0] BUILD_SECONDS = 32'h0000_0000,
  parameter logic [23:0] SERIAL_NUM    = 24'h00_0001,  // Arbitrary value
  parameter logic        ACCEL_SUPPORT = 1'b1,
  parameter logic [15:0] EXT_CODES     = 16'h8F0E       // Codes decoded elsewhere
) (
  // Clock and resets
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              wdog_rst,
  input  wire logic              cpu_rst,
  // Control-space access
  input  wire csr_pkg::cs_req_s  cs_in,
  output csr_pkg::cs_rsp_s       cs_out,
  // Device-space cycle and coprocessor timeout
  input  wire csr_pkg::dev_cyc_s dev_in,
  output csr_pkg::dev_rsp_s      dev_out,
  input  wire logic              cp_timeout,
  // System pins
  input  wire logic              diag_switch,
  output csr_pkg::sys_en_s       sys_en,
  output logic [7:0]             context_user_dma_permit,
  output logic [7:0]             led_latch
);
  import csr_pkg::*;

  logic [1:0] rst_sync_q;
  logic       rst_n;
  sys_en_s    fac_q;
  logic [7:0] dma_q;
  logic [7:0] flt_q;
  logic [7:0] led_q;
  cs_rsp_s    cs_q;
  dev_rsp_s   dev_q;
  cs_tgt_e    tgt;
  logic       cs_err;
  logic [7:0] dev_flt;
  logic       dev_upd;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Identity memory contents
  // byte layout
  function automatic logic [7:0] rom_raw(input logic [4:0] a);
    logic [7:0] b;
    b = 8'h00;
    if (a == 5'h00)
      b = ROM_FORMAT;
    else if (a == 5'h01)
      b = MACHINE_TYPE;
    else if (a < 5'h08)
      b = STATION_ADDR[8*(7-a) +: 8];
    else if (a < 5'h0C)
      b = BUILD_SECONDS[8*(11-a) +: 8];
    else if (a < 5'h0F)
      b = SERIAL_NUM[8*(14-a) +: 8];
    return b;
  endfunction

  // checksum folds the first fifteen bytes
  function automatic logic [7:0] rom_byte(input logic [4:0] a);
    logic [7:0] s;
    s = 8'h00;
    if (a == 5'(`ROM_CKSUM))
    begin
      for (int i = 0; i < `ROM_CKSUM; i++)
        s = s ^ rom_raw(5'(i));
    end
    else
      s = rom_raw(a);
    return s;
  endfunction

  // Control-space target decode
  function automatic cs_tgt_e decode(input logic [3:0] c);
    cs_tgt_e t;
    t = T_NONE;
    if (c == `CS_ROM)
      t = T_ROM;
    else if (c == `CS_FAC)
      t = T_FAC;
    else if (c == `CS_DMA)
      t = T_DMA;
    else if (c == `CS_FLT)
      t = T_FLT;
    else if (c == `CS_LED)
      t = T_LED;
    else if (EXT_CODES[c])
      t = T_EXT;
    return t;
  endfunction

  assign tgt = decode(cs_in.code);
  assign cs_err = cs_in.req && (tgt == T_NONE);

  // Device-space fault cause, one-hot or zero
  function automatic logic [7:0] fault_of(input dev_cyc_s d, input logic acc_en,
                                          input logic boot);
    logic [7:0] f;
    f = 8'h00;
    if (d.accel_sel)
    begin
      if (!acc_en)
        f[`FLT_ACCEL_DIS] = 1'b1;
      else if (!d.accel_present)
        f[`FLT_TIMEOUT] = 1'b1;
      else if (d.accel_err)
        f[`FLT_ACCEL_ERR] = 1'b1;
    end
    else if (ACCEL_SUPPORT && d.va_top >= `VA_TO_LO && d.va_top <= `VA_TO_HI)
      f[`FLT_TIMEOUT] = 1'b1;
    else if (boot && d.sup_fetch)
      f = 8'h00;
    else if (!d.pte_valid)
      f[`FLT_INVALID] = 1'b1;
    else if ((d.write && !d.pte_write) || (d.user && d.pte_super))
      f[`FLT_PROT] = 1'b1;
    else if (d.absent_target || (d.sysbus && d.sysbus_timeout))
      f[`FLT_TIMEOUT] = 1'b1;
    else if (d.sysbus && d.sysbus_berr)
      f[`FLT_SYSBUS] = 1'b1;
    return f;
  endfunction

  assign dev_flt = fault_of(dev_in, fac_q.accel, !fac_q.boot_n);
  assign dev_upd = dev_in.valid && !dev_in.dma && (dev_flt != 8'h00);

  // Facility enables, kept across processor reset
  // byte-wide read/write
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      fac_q <= `FAC_RST;
    else if (wdog_rst)
      fac_q <= `FAC_RST;
    else if (cs_in.req && cs_in.we && tgt == T_FAC)
      fac_q <= {cs_in.wdata[7:1], 1'b0};
  end

  // Context DMA permits
  // every reset clears them
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      dma_q <= `DMA_RST;
    else if (wdog_rst || cpu_rst)
      dma_q <= `DMA_RST;
    else if (cs_in.req && cs_in.we && tgt == T_DMA)
      dma_q <= cs_in.wdata;
  end

  // Fault cause latch
  // newest error overwrites
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      flt_q <= `FLT_RST;
    else if (cs_err)
      flt_q <= 8'(1 << `FLT_TIMEOUT);
    else if (dev_upd)
      flt_q <= dev_flt;
    else if (cp_timeout)
      flt_q <= 8'(1 << `FLT_TIMEOUT);
  end

  // LED latch, only power-on clears it
  // write-only display latch
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      led_q <= `LED_RST;
    else if (cs_in.req && cs_in.we && tgt == T_LED)
      led_q <= cs_in.wdata;
  end

  // Control-space answer, one cycle after request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cs_q <= '0;
    else
    begin
      cs_q.ack   <= cs_in.req && (tgt != T_EXT);
      cs_q.berr  <= cs_err;
      cs_q.rdata <= 8'h00;
      // writes to read-only targets are dropped
      if (cs_in.req && !cs_in.we)
      begin
        case (tgt)
          T_ROM:   cs_q.rdata <= rom_byte(cs_in.addr);
          T_FAC:   cs_q.rdata <= {fac_q[7:1], diag_switch};
          T_DMA:   cs_q.rdata <= dma_q;
          T_FLT:   cs_q.rdata <= {flt_q[7:2], 2'b00};
          default: cs_q.rdata <= 8'h00;
        endcase
      end
    end
  end

  // Device-space answer, one cycle after cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      dev_q <= '0;
    else
    begin
      dev_q.ack      <= dev_in.valid;
      dev_q.berr     <= dev_in.valid && (dev_flt != 8'h00);
      dev_q.to_eprom <= dev_in.valid && !fac_q.boot_n && dev_in.sup_fetch
                        && !dev_in.accel_sel;
      dev_q.to_accel <= dev_in.valid && dev_in.accel_sel && fac_q.accel;
    end
  end

  // Outputs
  assign cs_out                  = cs_q;
  assign dev_out                 = dev_q;
  assign sys_en                  = {fac_q[7:1], diag_switch};
  assign context_user_dma_permit = dma_q;
  assign led_latch               = led_q;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_write(logic [3:0] c);
    cs_in.req && cs_in.we && cs_in.code == c && !wdog_rst && !cpu_rst;
  endsequence

  sequence s_read(logic [3:0] c);
    cs_in.req && !cs_in.we && cs_in.code == c;
  endsequence

  a_cs_ack_timing: assert property (
    cs_in.req && tgt != T_EXT |=> cs_out.ack ##1 !cs_out.ack || $past(cs_in.req))
    else $error("control-space ack not one cycle after request");

  a_fac_write_back: assert property (
    s_write(`CS_FAC) ##1 (!wdog_rst && !cs_in.req)[*2] ##1 s_read(`CS_FAC) |=>
      cs_out.rdata[7:1] == $past(cs_in.wdata[7:1], 4))
    else $error("facility enables do not read back");

  a_fac_wdog_clear: assert property (
    wdog_rst |=> sys_en.boot_n == 1'b0 && fac_q == 8'h00)
    else $error("watchdog did not clear facility enables");

  a_fac_cpu_keep: assert property (
    cpu_rst && !wdog_rst && !cs_in.req |=> $stable(fac_q) && dma_q == 8'h00)
    else $error("processor reset handled facility or permits wrongly");

  a_diag_readback: assert property (
    s_read(`CS_FAC) |=> cs_out.rdata[0] == $past(diag_switch))
    else $error("diagnostic switch not on bit 0");

  a_dma_permit: assert property (
    s_write(`CS_DMA) |=> context_user_dma_permit == $past(cs_in.wdata))
    else $error("DMA permit write lost");

  a_unimpl_timeout: assert property (
    cs_in.req && tgt == T_NONE |=> cs_out.berr && flt_q == 8'h20)
    else $error("unknown control code did not time out");

  a_flt_read_only: assert property (
    s_write(`CS_FLT) && !dev_upd && !cp_timeout |=> $stable(flt_q))
    else $error("fault latch changed on write");

  a_accel_disabled: assert property (
    dev_in.valid && !dev_in.dma && dev_in.accel_sel && !fac_q.accel && !cs_err
      |=> dev_out.berr && flt_q == 8'h04 && !dev_out.to_accel)
    else $error("disabled accelerator access not faulted");

  a_dma_no_record: assert property (
    dev_in.valid && dev_in.dma && !cs_err && !cp_timeout |=> $stable(flt_q))
    else $error("DMA cycle changed fault latch");

  a_boot_steer: assert property (
    dev_in.valid && !fac_q.boot_n && dev_in.sup_fetch && !dev_in.accel_sel
      |=> dev_out.to_eprom)
    else $error("boot fetch not steered");

  a_rom_checksum: assert property (
    s_read(`CS_ROM) ##0 cs_in.addr == 5'(`ROM_CKSUM) |=>
      (cs_out.rdata ^ ROM_FORMAT ^ MACHINE_TYPE
      ^ STATION_ADDR[47:40] ^ STATION_ADDR[39:32] ^ STATION_ADDR[31:24]
      ^ STATION_ADDR[23:16] ^ STATION_ADDR[15:8] ^ STATION_ADDR[7:0]
      ^ BUILD_SECONDS[31:24] ^ BUILD_SECONDS[23:16] ^ BUILD_SECONDS[15:8]
      ^ BUILD_SECONDS[7:0] ^ SERIAL_NUM[23:16] ^ SERIAL_NUM[15:8] ^ SERIAL_NUM[7:0])
      == 8'h00)
    else $error("identity checksum wrong");

  a_led_write: assert property (
    cs_in.req && cs_in.we && cs_in.code == `CS_LED |=> led_latch == $past(cs_in.wdata))
    else $error("LED latch write lost");

endmodule
`default_nettype wire

// [tb/host_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  // Clock
  input  wire logic             ref_clk,
  // Control-space bus
  output var csr_pkg::cs_req_s  cs_in,
  input  wire csr_pkg::cs_rsp_s cs_out
);
  import csr_pkg::*;

  // Idle cycles placed before each request, for slow hosts
  int unsigned late;

  initial
  begin
    cs_in = '0;
    late = 0;
  end

  // One byte cycle: single request pulse, then a bounded wait for the answer
  task automatic access(input logic we, input logic [3:0] code, input logic [4:0] addr,
                        input logic [7:0] wd, output logic [7:0] rd, output logic berr,
                        output logic ok);
    cs_req_s r;
    r = '{req: 1'b1, we: we, code: code, addr: addr, wdata: wd};
    ok = 1'b0;
    rd = 8'h00;
    berr = 1'b0;
    repeat (late + 1) @(posedge ref_clk);
    cs_in <= r;
    @(posedge ref_clk);
    // Released lines show the inverse so stale values never pass
    r = ~r;
    r.req = 1'b0;
    cs_in <= r;
    for (int i = 0; i < 4 && ok == 1'b0; i++)
    begin
      @(posedge ref_clk);
      if (cs_out.ack === 1'b1)
      begin
        ok = 1'b1;
        rd = cs_out.rdata;
        berr = cs_out.berr;
      end
    end
  endtask
endmodule
`default_nettype wire

// [tb/control_space_system_registers_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"
module control_space_system_registers_tb_top;
  import csr_pkg::*;

  localparam logic [47:0] STATION = 48'h0A00_1B2C_3D4E;
  localparam logic [31:0] SECS    = 32'h2468_ACE0;
  localparam logic [23:0] SERIAL  = 24'h00_0357;  // Arbitrary value
  localparam logic [7:0]  MTYPE   = 8'h3C;        // Arbitrary value
  localparam logic [7:0]  EXP [9] = '{8'h20, 8'h08, 8'h20, 8'h80, 8'h40, 8'h40, 8'h20,
                                      8'h20, 8'h10};

  logic       ref_clk;
  logic       rstn;
  logic       wdog_rst;
  logic       cpu_rst;
  logic       cp_timeout;
  logic       diag_switch;
  cs_req_s    cs_in;
  cs_rsp_s    cs_out;
  dev_cyc_s   dev_in;
  dev_rsp_s   dev_out;
  dev_cyc_s   dc;
  sys_en_s    sys_en;
  logic [7:0] permit;
  logic [7:0] led;
  logic [7:0] rd;
  logic [7:0] v;
  logic [7:0] d;
  logic [7:0] x;
  logic       berr;
  logic       ok;
  int         n_fail;
  int         num_checks;

  always #12.5 ref_clk = ~ref_clk;

  control_space_regs #(.ROM_FORMAT(8'h01), .MACHINE_TYPE(MTYPE), .STATION_ADDR(STATION),
    .BUILD_SECONDS(SECS), .SERIAL_NUM(SERIAL), .ACCEL_SUPPORT(1'b1)) control_space_regs_i (
    .ref_clk(ref_clk), .rstn(rstn), .wdog_rst(wdog_rst), .cpu_rst(cpu_rst), .cs_in(cs_in),
    .cs_out(cs_out), .dev_in(dev_in), .dev_out(dev_out), .cp_timeout(cp_timeout),
    .diag_switch(diag_switch), .sys_en(sys_en), .context_user_dma_permit(permit),
    .led_latch(led));

  host_cpu_model host_cpu_model_i (.ref_clk(ref_clk), .cs_in(cs_in), .cs_out(cs_out));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Host cycle; a missing answer ends the run
  task automatic acc(input logic w, input logic [3:0] c, input logic [4:0] a,
                     input logic [7:0] wd);
    host_cpu_model_i.access(w, c, a, wd, rd, berr, ok);
    if (ok !== 1'b1)
    begin
      n_fail++;
      stop_test();
    end
  endtask

  // Device cycle; answer flags land in v
  task automatic dev(input dev_cyc_s c);
    @(posedge ref_clk);
    dev_in <= c;
    @(posedge ref_clk);
    c = ~c;
    c.valid = 1'b0;
    dev_in <= c;
    @(posedge ref_clk);
    v = {4'h0, dev_out.ack, dev_out.berr, dev_out.to_eprom, dev_out.to_accel};
  endtask

  // Expected identity byte, checksum worked out here
  function automatic logic [7:0] rom_exp(input int i);
    logic [127:0] b;
    logic [7:0]   s;
    b = {8'h01, MTYPE, STATION, SECS, SERIAL, 8'h00};
    s = 8'h00;
    for (int j = 0; j < 15; j++)
      s ^= b[127 - 8 * j -: 8];
    b[7:0] = s;
    return (i < 16) ? b[127 - 8 * i -: 8] : 8'h00;
  endfunction

  // Device cycle for one fault case, otherwise clean
  function automatic dev_cyc_s mk(input int k);
    dev_cyc_s c;
    c = '0;
    {c.valid, c.pte_valid, c.pte_write} = 3'b111;
    case (k)
      0: c.accel_sel = 1'b1;
      1: {c.accel_sel, c.accel_present, c.accel_err} = 3'b111;
      2: c.va_top = 4'(1 + $urandom_range(12));
      3: c.pte_valid = 1'b0;
      4: {c.write, c.pte_write} = 2'b10;
      5: {c.user, c.pte_super} = 2'b11;
      6: c.absent_target = 1'b1;
      7: {c.sysbus, c.sysbus_timeout} = 2'b11;
      8: {c.sysbus, c.sysbus_berr} = 2'b11;
      default: c.sup_fetch = 1'b1;
    endcase
    return c;
  endfunction

  initial
  begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    wdog_rst = 1'b0;
    cpu_rst = 1'b0;
    cp_timeout = 1'b0;
    diag_switch = 1'b1;
    dev_in = '0;
    void'($urandom(32'h95C76ACD));
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    acc(1'b0, `CS_FAC, 5'h00, 8'h00);
    chk("fac reset", 8'h01, rd);
    acc(1'b0, `CS_DMA, 5'h00, 8'h00);
    chk("permit reset", 8'h00, rd);
    chk("led reset", 8'h00, led);
    x = 8'h00;
    for (int i = 0; i < 32; i++)
    begin
      acc(1'b0, `CS_ROM, 5'(i), 8'h00);
      chk("rom byte", rom_exp(i), rd);
      x = (i < 16) ? x ^ rd : x;
    end
    chk("rom xor", 8'h00, x);
    acc(1'b1, `CS_ROM, 5'h08, 8'hFF);
    acc(1'b0, `CS_ROM, 5'h08, 8'h00);
    chk("rom date", rom_exp(8), rd);
    for (int c = 12; c < 15; c++)
    begin
      acc(1'b0, 4'(c), 5'h00, 8'h00);
      chk("code berr", 8'h01, {7'h00, berr});
      acc(1'b1, `CS_FLT, 5'h00, 8'h00);
      acc(1'b0, `CS_FLT, 5'h00, 8'h00);
      chk("fault code", 8'h20, rd);
    end
    // Codes served outside get no local answer
    host_cpu_model_i.access(1'b0, 4'h8, 5'h00, 8'h00, rd, berr, ok);
    chk("ext no ack", 8'h00, {7'h00, ok});
    $display("reset and identity tests done");
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($urandom);
      diag_switch <= 1'($urandom);
      host_cpu_model_i.late = $urandom_range(3);
      acc(1'b1, `CS_FAC, 5'h00, d);
      acc(1'b0, `CS_FAC, 5'h00, 8'h00);
      chk("fac", {d[7:1], diag_switch}, rd);
      chk("sys_en", {d[7:1], diag_switch}, sys_en);
      acc(1'b1, `CS_DMA, 5'h00, ~d);
      acc(1'b0, `CS_DMA, 5'h00, 8'h00);
      chk("permit", ~d, rd);
      chk("permit port", ~d, permit);
      acc(1'b1, `CS_LED, 5'h00, d ^ 8'h3C);
      chk("led", d ^ 8'h3C, led);
      acc(1'b0, `CS_LED, 5'h00, 8'h00);
      chk("led read", 8'h00, rd);
    end
    $display("register tests done");
    host_cpu_model_i.late = 0;
    acc(1'b1, `CS_FAC, 5'h00, 8'hFE);
    acc(1'b0, `CS_FAC, 5'h00, 8'h00);
    chk("fac readback", {7'h7F, diag_switch}, rd);
    acc(1'b1, `CS_DMA, 5'h00, 8'hA5);
    acc(1'b1, `CS_LED, 5'h00, 8'h5A);
    cpu_rst <= 1'b1;
    @(posedge ref_clk);
    cpu_rst <= 1'b0;
    acc(1'b0, `CS_FAC, 5'h00, 8'h00);
    chk("fac cpu reset", {7'h7F, diag_switch}, rd);
    chk("permit cpu reset", 8'h00, permit);
    acc(1'b1, `CS_DMA, 5'h00, 8'hA5);
    wdog_rst <= 1'b1;
    @(posedge ref_clk);
    wdog_rst <= 1'b0;
    acc(1'b0, `CS_FAC, 5'h00, 8'h00);
    chk("fac watchdog", {7'h00, diag_switch}, rd);
    chk("permit watchdog", 8'h00, permit);
    chk("led watchdog", 8'h5A, led);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("led power on", 8'h00, led);
    $display("reset source tests done");
    acc(1'b1, `CS_FAC, 5'h00, 8'h80);
    dev(mk(0));
    chk("accel off berr", 8'h0C, v);
    acc(1'b0, `CS_FLT, 5'h00, 8'h00);
    chk("accel off cause", 8'h04, rd);
    acc(1'b1, `CS_FAC, 5'h00, 8'h82);
    for (int k = 0; k < 9; k++)
    begin
      dev(mk(k));
      chk("dev flags", (k < 2) ? 8'h0D : 8'h0C, v);
      acc(1'b0, `CS_FLT, 5'h00, 8'h00);
      chk("dev cause", EXP[k], rd);
    end
    dc = mk(3);
    dc.dma = 1'b1;
    dev(dc);
    acc(1'b0, `CS_FLT, 5'h00, 8'h00);
    chk("dma keeps cause", 8'h10, rd);
    cp_timeout <= 1'b1;
    @(posedge ref_clk);
    cp_timeout <= 1'b0;
    acc(1'b0, `CS_FLT, 5'h00, 8'h00);
    chk("coproc cause", 8'h20, rd);
    dev(mk(9));
    chk("normal fetch", 8'h08, v);
    acc(1'b1, `CS_FAC, 5'h00, 8'h02);
    dev(mk(9));
    chk("boot fetch", 8'h0A, v);
    $display("device fault tests done");
    stop_test();
  end
endmodule
`default_nettype wire
